// ---- clkms_ctrl.sv ----
// Purpose: clock generator mode control with apb register access
// Assumes: oscillator ready and loop lock arrive from analog blocks, synchronous to pclk
// Notes:   outputs steer the clock multiplexers, dividers and loop enables
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - reset leaves the generator in fll engaged internal mode
// - source select %10 routes the external reference to the output
// - status source field reads %10 once external reference drives the output
// - source select %01 routes internal reference; status then reads %01
// - select %00 with fll chosen drives fll output; status reads %00
// - select %00 with pll chosen drives pll output; status reads %11
// - reference divider field divides by two to the power of its value
// - reference select bit picks internal when 1; status bit reports source in use
// - low power bit in bypassed mode disables both loops; clearing restores
// - loop select bit picks fll or pll; status bit reports current loop
// - multiplier field sets pll factor, %0100 gives 16, ignored for fll
// - fll keeps running while bypassed unless pll or low power is chosen; lock bit sets when selected loop locks
// - oscillator ready bit sets when crystal chosen by type bit is initialised
// - control two holds range, high gain and external reference enable bits
// - output divider %00 divides by one; bus clock is output over two
// - pll engaged output is reference over divider times multiplier over divider
module clkms_ctrl
	import clkms_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [CLKMS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    osc_ready_in,
	input  wire logic                    loop_locked_in,
	output clkms_cfg_t                   gen_cfg
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	clkms_state_t state_ff;
	clkms_state_t nxt_state;

	logic       addr_hit;
	logic       wr_en;
	logic       low_power_eff;
	logic [1:0] req_src;
	clkms_src_t tgt_clk;
	logic       lock_stat;
	logic       osc_rdy_stat;
	logic [7:0] status_byte;

	// ----------------------------------------------------------------
	// decode and status
	// ----------------------------------------------------------------
	always_comb begin
		addr_hit = (paddr == CLKMS_OFS_CONTROL_ONE) || (paddr == CLKMS_OFS_CONTROL_TWO) ||
			(paddr == CLKMS_OFS_CONTROL_THR) || (paddr == CLKMS_OFS_STATUS);
		wr_en    = psel && penable && pwrite && addr_hit && pstrb[0];
		req_src  = state_ff.control_one[CLKMS_SRC_SEL_LSB +: 2];
		// low power only counts while the source select is not %00
		low_power_eff = state_ff.control_two[CLKMS_LOW_POWER_BIT] &&
			(req_src != 2'h0);
		// code %11 is reserved: the multiplexer keeps its present choice
		unique case (req_src)
			2'h0: tgt_clk = state_ff.pll_applied ? CLKMS_SRC_PLL : CLKMS_SRC_FLL;
			2'h1: tgt_clk = CLKMS_SRC_INT;
			2'h2: tgt_clk = CLKMS_SRC_EXT;
			2'h3: tgt_clk = state_ff.clk_applied;
		endcase
		// lock is withheld while a loop switch is still settling
		lock_stat = loop_locked_in && !low_power_eff &&
			(state_ff.pll_applied ==
			state_ff.control_three[CLKMS_LOOP_SEL_BIT]);
		osc_rdy_stat = osc_ready_in &&
			state_ff.control_two[CLKMS_EXT_REF_TYPE_BIT];
		status_byte = 8'h00;
		status_byte[CLKMS_ST_LOCK_BIT]    = lock_stat;
		status_byte[CLKMS_ST_LOOP_BIT]    = state_ff.pll_applied;
		status_byte[CLKMS_ST_INT_REF_BIT] = state_ff.ref_int_applied;
		status_byte[CLKMS_ST_SRC_LSB +: 2] = state_ff.clk_applied;
		status_byte[CLKMS_ST_OSC_RDY_BIT] = osc_rdy_stat;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;

		// register writes take effect in the access phase
		if (wr_en) begin
			unique case (paddr)
				CLKMS_OFS_CONTROL_ONE: nxt_state.control_one   = pwdata[7:0];
				CLKMS_OFS_CONTROL_TWO: nxt_state.control_two   = pwdata[7:0];
				CLKMS_OFS_CONTROL_THR: nxt_state.control_three = pwdata[7:0];
				default: nxt_state.rdata = state_ff.rdata;
			endcase
		end

		// read data is captured in the setup phase so the access phase needs no wait
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CLKMS_OFS_CONTROL_ONE: nxt_state.rdata = {24'h000000, state_ff.control_one};
				CLKMS_OFS_CONTROL_TWO: nxt_state.rdata = {24'h000000, state_ff.control_two};
				CLKMS_OFS_CONTROL_THR: nxt_state.rdata = {24'h000000, state_ff.control_three};
				CLKMS_OFS_STATUS:      nxt_state.rdata = {24'h000000, status_byte};
				default:               nxt_state.rdata = 32'h00000000;
			endcase
		end

		// clock multiplexer: hold the old source until both clocks have settled
		if (tgt_clk != state_ff.clk_applied) begin
			if (state_ff.clk_cnt == CLKMS_SWITCH_CYC - 3'h1) begin
				nxt_state.clk_applied = tgt_clk;
				nxt_state.clk_cnt     = 3'h0;
			end else begin
				nxt_state.clk_cnt = state_ff.clk_cnt + 3'h1;
			end
		end else begin
			nxt_state.clk_cnt = 3'h0;
		end

		// reference multiplexer
		if (state_ff.control_one[CLKMS_INT_REF_SEL_BIT] != state_ff.ref_int_applied) begin
			if (state_ff.ref_cnt == CLKMS_SWITCH_CYC - 3'h1) begin
				nxt_state.ref_int_applied =
					state_ff.control_one[CLKMS_INT_REF_SEL_BIT];
				nxt_state.ref_cnt = 3'h0;
			end else begin
				nxt_state.ref_cnt = state_ff.ref_cnt + 3'h1;
			end
		end else begin
			nxt_state.ref_cnt = 3'h0;
		end

		// loop multiplexer, also switched while both loops sleep in low power
		if (state_ff.control_three[CLKMS_LOOP_SEL_BIT] != state_ff.pll_applied) begin
			if (state_ff.loop_cnt == CLKMS_SWITCH_CYC - 3'h1) begin
				nxt_state.pll_applied =
					state_ff.control_three[CLKMS_LOOP_SEL_BIT];
				nxt_state.loop_cnt = 3'h0;
			end else begin
				nxt_state.loop_cnt = state_ff.loop_cnt + 3'h1;
			end
		end else begin
			nxt_state.loop_cnt = 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// source %00, internal reference, fll loop: fll engaged internal
			state_ff.control_one     <= CLKMS_RST_CONTROL_ONE;
			state_ff.control_two     <= CLKMS_RST_CONTROL_TWO;
			state_ff.control_three   <= CLKMS_RST_CONTROL_THR;
			state_ff.clk_applied     <= CLKMS_SRC_FLL;
			state_ff.ref_int_applied <= 1'b1;
			state_ff.pll_applied     <= 1'b0;
			state_ff.clk_cnt         <= 3'h0;
			state_ff.ref_cnt         <= 3'h0;
			state_ff.loop_cnt        <= 3'h0;
			state_ff.rdata           <= 32'h00000000;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// apb answer
	// ----------------------------------------------------------------
	always_comb begin
		pready  = 1'b1;
		pslverr = psel && penable && !addr_hit;
		prdata  = state_ff.rdata;
	end

	// ----------------------------------------------------------------
	// generator configuration
	// ----------------------------------------------------------------
	always_comb begin
		gen_cfg.mux_sel      = state_ff.clk_applied;
		gen_cfg.ref_internal = state_ff.ref_int_applied;
		// the fll runs even when bypassed, only low power or a pll loop choice stops it
		// a loop stays on while the output mux still takes it, else the output clock dies
		gen_cfg.fll_enable   = (!low_power_eff && !state_ff.pll_applied) ||
			(state_ff.clk_applied == CLKMS_SRC_FLL);
		gen_cfg.pll_enable   = (!low_power_eff && state_ff.pll_applied) ||
			(state_ff.clk_applied == CLKMS_SRC_PLL);
		gen_cfg.ref_div_ratio =
			8'h01 << state_ff.control_one[CLKMS_REF_DIV_LSB +: 3];
		// loop_multiplier steps are times four; the fll factor is fixed
		gen_cfg.loop_mult = state_ff.pll_applied ?
			{5'h00, state_ff.control_three[CLKMS_MULT_LSB +: 4], 2'h0} :
			CLKMS_FLL_MULT;
		gen_cfg.out_div_ratio =
			4'h1 << state_ff.control_two[CLKMS_OUT_DIV_LSB +: 2];
		gen_cfg.bus_div_ratio = CLKMS_BUS_DIV;
		// keep the oscillator alive when software asks or the design uses it
		gen_cfg.ext_ref_enable = state_ff.control_two[CLKMS_EXT_REF_EN_BIT] ||
			!state_ff.ref_int_applied || (state_ff.clk_applied == CLKMS_SRC_EXT);
		gen_cfg.freq_range_high = state_ff.control_two[CLKMS_FREQ_RANGE_BIT];
		gen_cfg.high_gain       = state_ff.control_two[CLKMS_HIGH_GAIN_BIT];
		gen_cfg.crystal_sel     = state_ff.control_two[CLKMS_EXT_REF_TYPE_BIT];
	end

endmodule // clkms_ctrl

// ---- clkms_ctrl_chk.sv ----
// Purpose: port assertions for the clock mode switch control
// Assumes: one pclk domain, asynchronous active-low presetn
// Notes:   switch figures follow the four-edge settle of the muxes
`timescale 1ns/1ps
module clkms_ctrl_chk
	import clkms_pkg::*;
(
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [CLKMS_ADDR_W-1:0] paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    osc_ready_in,
	input wire logic                    loop_locked_in,
	input wire clkms_cfg_t              gen_cfg
);
	// ----------------------------------------------------------------
	// write phases and settle sequences
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence wr_one_s;
		psel && penable && pwrite && pstrb[0] && paddr == CLKMS_OFS_CONTROL_ONE;
	endsequence
	sequence wr_two_s;
		psel && penable && pwrite && pstrb[0] && paddr == CLKMS_OFS_CONTROL_TWO;
	endsequence
	// old source must hold while the glitch-free mux settles
	sequence to_ext_s;
		(gen_cfg.mux_sel != CLKMS_SRC_EXT)[*3] ##2 gen_cfg.mux_sel == CLKMS_SRC_EXT;
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_RESET_FEI: assert property ($rose(presetn) |-> gen_cfg.mux_sel == CLKMS_SRC_FLL
		&& gen_cfg.ref_internal && gen_cfg.fll_enable) else $error("reset mode wrong");
	AST_EXT_SWITCH: assert property (wr_one_s ##0 (pwdata[7:6] == 2'h2
		&& gen_cfg.mux_sel != CLKMS_SRC_EXT) |=> to_ext_s) else $error("ext switch timing");
	AST_INT_SWITCH: assert property (wr_one_s ##0 (pwdata[7:6] == 2'h1
		&& gen_cfg.mux_sel != CLKMS_SRC_INT) |-> ##[4:5] gen_cfg.mux_sel == CLKMS_SRC_INT)
		else $error("int switch timing");
	AST_REF_SWITCH: assert property (wr_one_s ##0 (!pwdata[2] && gen_cfg.ref_internal)
		|=> gen_cfg.ref_internal[*3] ##2 !gen_cfg.ref_internal) else $error("ref switch timing");
	AST_PLL_RUNS: assert property (gen_cfg.mux_sel == CLKMS_SRC_PLL |-> gen_cfg.pll_enable)
		else $error("pll output without pll");
	AST_FLL_RUNS: assert property (gen_cfg.mux_sel == CLKMS_SRC_FLL |-> gen_cfg.fll_enable)
		else $error("fll output without fll");
	AST_REF_DIV: assert property (wr_one_s |=>
		gen_cfg.ref_div_ratio == 8'h01 << $past(pwdata[5:3])) else $error("ref divider wrong");
	AST_OUT_DIV: assert property (wr_two_s |=>
		gen_cfg.out_div_ratio == 4'h1 << $past(pwdata[7:6])) else $error("out divider wrong");
	AST_BUS_DIV: assert property (gen_cfg.bus_div_ratio == CLKMS_BUS_DIV)
		else $error("bus divider wrong");
	AST_LOW_POWER: assert property (wr_two_s ##0 (pwdata[3] && gen_cfg.mux_sel == CLKMS_SRC_EXT)
		|-> ##[1:6] !gen_cfg.fll_enable && !gen_cfg.pll_enable) else $error("loops still on");
endmodule // clkms_ctrl_chk

bind clkms_ctrl clkms_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .osc_ready_in, .loop_locked_in, .gen_cfg);

// ---- clkms_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the clock mode switch control
// Assumes: apb master waits on pready, status polled with a bound
// Notes:   every access notes its expectation in a queue for the monitor
`timescale 1ns/1ps
module clkms_ctrl_tb_top
	import clkms_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_ready_in, loop_locked_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, seed;
	logic [3:0]  pstrb;
	clkms_cfg_t  gen_cfg;
	logic [64:0] exp_q[$];
	int          n_mismatch, compares;

	clkms_ctrl u_clkms_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .osc_ready_in, .loop_locked_in, .gen_cfg);

	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// polls carry a zero mask so only pslverr is judged
	always @(posedge pclk) begin : mon
		logic [64:0] e;
		if (psel && penable && pready) begin
			e = exp_q.pop_front();
			chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
		end
	end
	// ----------------------------------------------------------------
	// apb master
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [64:0] e);
		@(posedge pclk);
		exp_q.push_back(e);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rv = prdata;
		psel <= 1'h0; penable <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'h1, a, {24'h0, d}, 65'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic err);
		xfer(1'h0, a, 32'h0, {err, 32'hFFFFFFFF, 24'h0, v});
	endtask
	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		int i;
		i = 0;
		do begin
			xfer(1'h0, CLKMS_OFS_STATUS, 32'h0, 65'h0);
			i++;
		end while ((rv[7:0] & m) !== v && i < 60);
		chk({32'h0, (rv[7:0] & m) === v}, 33'h1);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// mode walk
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, osc_ready_in, loop_locked_in} = '0;
		paddr = '0; pwdata = '0; pstrb = '0; seed = 32'h4617;
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		chk({20'h0, gen_cfg.mux_sel, gen_cfg.ref_internal, gen_cfg.fll_enable, gen_cfg.pll_enable,
			gen_cfg.ref_div_ratio}, {20'h0, CLKMS_SRC_FLL, 3'h6, 8'h01});
		rd(CLKMS_OFS_CONTROL_ONE, 8'h04, 1'h0);
		rd(CLKMS_OFS_CONTROL_TWO, 8'h00, 1'h0);
		rd(CLKMS_OFS_CONTROL_THR, 8'h00, 1'h0);
		wr(CLKMS_OFS_STATUS, 8'hFF);
		rd(CLKMS_OFS_STATUS, 8'h10, 1'h0);
		rd(12'h010, 8'h00, 1'h1);
		wr(CLKMS_OFS_CONTROL_TWO, 8'h36);
		osc_ready_in <= 1'h1;
		rd(CLKMS_OFS_CONTROL_TWO, 8'h36, 1'h0);
		chk({29'h0, gen_cfg.freq_range_high, gen_cfg.high_gain, gen_cfg.crystal_sel,
			gen_cfg.ext_ref_enable}, 33'hF);
		poll(8'h02, 8'h02);
		wr(CLKMS_OFS_CONTROL_ONE, 8'hB8);
		poll(8'h1C, 8'h08);
		loop_locked_in <= 1'h1;
		rd(CLKMS_OFS_STATUS, 8'h4A, 1'h0);
		chk({25'h0, gen_cfg.ref_div_ratio}, 33'h80);
		wr(CLKMS_OFS_CONTROL_TWO, 8'h3E);
		repeat (CLKMS_SWITCH_CYC + 2) @(posedge pclk);
		chk({31'h0, gen_cfg.fll_enable, gen_cfg.pll_enable}, 33'h0);
		wr(CLKMS_OFS_CONTROL_ONE, 8'h98);
		wr(CLKMS_OFS_CONTROL_THR, 8'h44);
		poll(8'h20, 8'h20);
		wr(CLKMS_OFS_CONTROL_TWO, 8'h36);
		poll(8'h40, 8'h40);
		chk({21'h0, gen_cfg.pll_enable, gen_cfg.loop_mult}, {21'h0, 1'h1, 11'h010});
		wr(CLKMS_OFS_CONTROL_ONE, 8'h18);
		poll(8'h0C, 8'h0C);
		rd(CLKMS_OFS_STATUS, 8'h6E, 1'h0);
		chk({10'h0, gen_cfg.ref_div_ratio, gen_cfg.loop_mult, gen_cfg.out_div_ratio},
			{10'h0, 8'h08, 11'h010, 4'h1});
		wr(CLKMS_OFS_CONTROL_THR, 8'h04);
		poll(8'h2C, 8'h00);
		wr(CLKMS_OFS_CONTROL_ONE, 8'h44);
		poll(8'h1C, 8'h14);
		rd(CLKMS_OFS_STATUS, 8'h56, 1'h0);
		wr(CLKMS_OFS_CONTROL_ONE, 8'h04);
		poll(8'h0C, 8'h00);
		rd(CLKMS_OFS_STATUS, 8'h52, 1'h0);
		// reserved source code: the output must stay on the fll
		wr(CLKMS_OFS_CONTROL_ONE, 8'hC4);
		repeat (CLKMS_SWITCH_CYC + 2) @(posedge pclk);
		rd(CLKMS_OFS_STATUS, 8'h52, 1'h0);
		rd(CLKMS_OFS_CONTROL_ONE, 8'hC4, 1'h0);
		repeat (6) begin
			seed = lfsr(seed);
			wr(CLKMS_OFS_CONTROL_TWO, seed[7:0]);
			rd(CLKMS_OFS_CONTROL_TWO, seed[7:0], 1'h0);
			chk({29'h0, gen_cfg.out_div_ratio}, {29'h0, 4'h1 << seed[7:6]});
		end
		end_of_test();
	end
	initial begin
		#400000;
		n_mismatch++;
		end_of_test();
	end
endmodule // clkms_ctrl_tb_top

// ---- clkms_pkg.sv ----
// Purpose: shared constants and types for the clock mode switch control block
// Assumes: apb register map with 32-bit aligned words, 8-bit registers in the low byte
// Notes:   switch settle time models the glitch-free clock and reference multiplexers
package clkms_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          CLKMS_ADDR_W           = 12;
	localparam logic [11:0] CLKMS_OFS_CONTROL_ONE  = 12'h000;
	localparam logic [11:0] CLKMS_OFS_CONTROL_TWO  = 12'h004;
	localparam logic [11:0] CLKMS_OFS_CONTROL_THR  = 12'h008;
	localparam logic [11:0] CLKMS_OFS_STATUS       = 12'h00C;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CLKMS_RST_CONTROL_ONE  = 8'h04;
	localparam logic [7:0]  CLKMS_RST_CONTROL_TWO  = 8'h00;
	localparam logic [7:0]  CLKMS_RST_CONTROL_THR  = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CLKMS_SRC_SEL_LSB      = 6;
	localparam int CLKMS_REF_DIV_LSB      = 3;
	localparam int CLKMS_INT_REF_SEL_BIT  = 2;
	localparam int CLKMS_OUT_DIV_LSB      = 6;
	localparam int CLKMS_FREQ_RANGE_BIT   = 5;
	localparam int CLKMS_HIGH_GAIN_BIT    = 4;
	localparam int CLKMS_LOW_POWER_BIT    = 3;
	localparam int CLKMS_EXT_REF_TYPE_BIT = 2;
	localparam int CLKMS_EXT_REF_EN_BIT   = 1;
	localparam int CLKMS_LOOP_SEL_BIT     = 6;
	localparam int CLKMS_MULT_LSB         = 0;
	localparam int CLKMS_ST_LOCK_BIT      = 6;
	localparam int CLKMS_ST_LOOP_BIT      = 5;
	localparam int CLKMS_ST_INT_REF_BIT   = 4;
	localparam int CLKMS_ST_SRC_LSB       = 2;
	localparam int CLKMS_ST_OSC_RDY_BIT   = 1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLKMS_CLK_PERIOD_PS = 25000;
	localparam int         CLKMS_SWITCH_NS     = 100;
	localparam int         CLKMS_SWITCH_CYC_I  =
		(CLKMS_SWITCH_NS * 1000 + CLKMS_CLK_PERIOD_PS - 1) / CLKMS_CLK_PERIOD_PS;
	localparam logic [2:0] CLKMS_SWITCH_CYC    = 3'(CLKMS_SWITCH_CYC_I);
	localparam logic [1:0] CLKMS_BUS_DIV       = 2'h2;
	localparam logic [10:0] CLKMS_FLL_MULT     = 11'h400;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CLKMS_SRC_FLL = 2'h0,
		CLKMS_SRC_INT = 2'h1,
		CLKMS_SRC_EXT = 2'h2,
		CLKMS_SRC_PLL = 2'h3
	} clkms_src_t;

	typedef struct packed {
		clkms_src_t  mux_sel;
		logic        ref_internal;
		logic        fll_enable;
		logic        pll_enable;
		logic [7:0]  ref_div_ratio;
		logic [10:0] loop_mult;
		logic [3:0]  out_div_ratio;
		logic [1:0]  bus_div_ratio;
		logic        ext_ref_enable;
		logic        freq_range_high;
		logic        high_gain;
		logic        crystal_sel;
	} clkms_cfg_t;

	typedef struct packed {
		logic [7:0]  control_one;
		logic [7:0]  control_two;
		logic [7:0]  control_three;
		clkms_src_t  clk_applied;
		logic        ref_int_applied;
		logic        pll_applied;
		logic [2:0]  clk_cnt;
		logic [2:0]  ref_cnt;
		logic [2:0]  loop_cnt;
		logic [31:0] rdata;
	} clkms_state_t;

endpackage
